// file: dv/spcc_chk.sv
// Assertions on the image words between the host and device ends
`include "spcc_params.svh"

module spcc_chk (
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Synchronous reset
  input wire spcc_pkg::spcc_word_type bit_cmd, // Output word 4
  input wire spcc_pkg::spcc_word_type blk_cmd, // Output word 5
  input wire spcc_pkg::spcc_word_type err_status, // Input word 4
  input wire spcc_pkg::spcc_word_type blk_echo // Command being answered
);
  import spcc_pkg::*;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  spcc_word_type prev_echo;
  always_ff @(posedge clk_i)
  begin
    prev_echo <= reset_i ? 16'h0000 : blk_echo;
  end
  // First cycle of an answer
  wire logic fresh = (blk_echo != 16'h0000) && (prev_echo == 16'h0000);
  wire logic bad_low = (blk_cmd[7:0] != 8'h00) && (blk_cmd[7:0] != 8'h08) && (blk_cmd[7:0] != 8'h10);
  wire logic too_many = $countones(blk_cmd[15:8]) > 3;

  a_echo_answer: assert property (
    (blk_cmd != 16'h0000 && $past(blk_cmd) == 16'h0000 && blk_echo == 16'h0000) |-> ##[1:3] blk_echo == blk_cmd)
    else $error("no answer to new command");
  a_echo_release: assert property (
    (blk_echo != 16'h0000 && blk_cmd == 16'h0000) |=> blk_echo == 16'h0000)
    else $error("answer not released");
  a_echo_holds: assert property (
    (blk_echo != 16'h0000 && blk_cmd != 16'h0000) |=> blk_echo == $past(blk_echo))
    else $error("answer changed while word held");
  a_err_stands: assert property (
    blk_echo != 16'h0000 |=> $stable(err_status))
    else $error("error status moved while held");
  a_bad_word4: assert property (
    (fresh && bit_cmd != 16'h0000) |-> err_status == `SPCC_ERR_BAD_CMD)
    else $error("nonzero word 4 accepted");
  a_bad_low: assert property (
    (fresh && bad_low) |-> err_status == `SPCC_ERR_BAD_CMD)
    else $error("unknown lower command accepted");
  a_bad_mix: assert property (
    (fresh && blk_cmd[7:0] != 8'h00 && blk_cmd[15:8] != 8'h00) |-> err_status == `SPCC_ERR_BAD_CMD)
    else $error("mixed command accepted");
  a_bad_count: assert property (
    (fresh && too_many) |-> err_status == `SPCC_ERR_BAD_CMD)
    else $error("more than three bits accepted");
  a_cfg_anytime: assert property (
    (fresh && bit_cmd == 16'h0000 && blk_cmd[7:0] == 8'h00 && !too_many)
    |-> err_status inside {`SPCC_ERR_NONE, `SPCC_ERR_RANGE})
    else $error("config refused by state");
  a_err_code: assert property (
    err_status <= `SPCC_ERR_BAD_CMD)
    else $error("undefined error code");
endmodule : spcc_chk

// file: dv/tb.sv
// Self-checking bench: host and device ends joined by the image-word interface
`include "spcc_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import spcc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_i = 1'b0;
  logic estop_i = 1'b0;
  logic motion_i = 1'b0;
  logic homed_i = 1'b1;
  logic home_done_i = 1'b0;
  logic ce_i = 1'b1;
  logic cmd_done_o;
  logic busy_o;
  logic done_o;
  logic in_position_o;
  spcc_word_type bits_i = 16'h0000;
  spcc_word_type cmd_i = 16'h0000;
  spcc_word_type err_o;
  spcc_value_type par0_i = 32'h0, par1_i = 32'h0, par2_i = 32'h0;
  spcc_value_type following_error_i = 32'h3, lim_i = 32'h3e8, act_i = 32'h0, end_i = 32'h0;
  spcc_value_type cmd_pos_o, abs_pos_o, offset_o, band_o, following_error_limit_o, target_o;
  int failures = 0;
  int comparisons = 0;

  always #12.5 clk_i = ~clk_i;

  spcc_if spcc_if_i ();
  spcc_device spcc_device_i (.clk_i, .reset_i, .ce_i, .link(spcc_if_i), .estop_i, .motion_i, .homed_i,
    .home_done_i, .following_error_i, .travel_limit_i(lim_i), .actual_pos_i(act_i), .move_end_i(end_i),
    .cmd_pos_o, .abs_pos_o, .offset_o, .band_o, .following_error_limit_o, .target_o, .in_position_o,
    .cmd_done_o);
  spcc_host spcc_host_i (.clk_i, .reset_i, .ce_i, .link(spcc_if_i), .req_i, .bits_i, .cmd_i, .par0_i,
    .par1_i, .par2_i, .busy_o, .done_o, .err_o);
  spcc_chk spcc_chk_i (.clk_i, .reset_i, .bit_cmd(spcc_if_i.bit_cmd), .blk_cmd(spcc_if_i.blk_cmd),
    .err_status(spcc_if_i.err_status), .blk_echo(spcc_if_i.blk_echo));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One full command through the host end, then its error code
  task automatic issue(input spcc_word_type b, input spcc_word_type c, input spcc_value_type p0,
    input spcc_value_type p1, input spcc_value_type p2, input spcc_word_type e);
    int n;
    int pulses;
    int busy_cycles;
    @(posedge clk_i);
    req_i <= 1'b1;
    bits_i <= b;
    cmd_i <= c;
    par0_i <= p0;
    par1_i <= p1;
    par2_i <= p2;
    @(posedge clk_i);
    req_i <= 1'b0;
    n = 0;
    pulses = 0;
    busy_cycles = 0;
    while (done_o !== 1'b1 && n < 40)
    begin
      @(posedge clk_i);
      n++;
      if (cmd_done_o === 1'b1)
        pulses++;
      if (busy_o === 1'b1)
        busy_cycles++;
    end
    check({31'h0, done_o}, 32'h1);
    check(pulses, 32'h1);
    check({31'h0, (busy_cycles > 0)}, 32'h1);
    check({31'h0, busy_o}, 32'h0);
    repeat (2) @(posedge clk_i);
    check({16'h0000, err_o}, {16'h0000, e});
  endtask : issue

  task automatic t_preset;
    issue(16'h0000, 16'h0008, 32'h5, 32'h0, 32'h0, `SPCC_ERR_NONE);
    check(cmd_pos_o, 32'h5);
    check(abs_pos_o, 32'h8);
  endtask : t_preset

  task automatic t_refuse;
    estop_i <= 1'b1;
    issue(16'h0000, 16'h0008, 32'h9, 32'h0, 32'h0, `SPCC_ERR_ESTOP);
    estop_i <= 1'b0;
    motion_i <= 1'b1;
    issue(16'h0000, 16'h0008, 32'h9, 32'h0, 32'h0, `SPCC_ERR_MOTION);
    motion_i <= 1'b0;
    homed_i <= 1'b0;
    issue(16'h0000, 16'h0008, 32'h9, 32'h0, 32'h0, `SPCC_ERR_NOT_HOMED);
    homed_i <= 1'b1;
    issue(16'h0000, 16'h0008, 32'h3e9, 32'h0, 32'h0, `SPCC_ERR_RANGE);
    check(cmd_pos_o, 32'h5);
  endtask : t_refuse

  task automatic t_config;
    estop_i <= 1'b1;
    motion_i <= 1'b1;
    issue(16'h0000, 16'h0100, 32'h3e8, 32'h0, 32'h0, `SPCC_ERR_NONE);
    check(band_o, 32'h3e8);
    issue(16'h0000, 16'h0300, 32'h14, 32'h32, 32'h0, `SPCC_ERR_NONE);
    check(band_o, 32'h14);
    check(following_error_limit_o, 32'h32);
    issue(16'h0000, 16'h0600, 32'h46, 32'h0, 32'h0, `SPCC_ERR_NONE);
    check(following_error_limit_o, 32'h46);
    issue(16'h0000, 16'h0200, 32'hffff_ffff, 32'h0, 32'h0, `SPCC_ERR_RANGE);
    issue(16'h0000, 16'h0100, 32'h3e9, 32'h0, 32'h0, `SPCC_ERR_RANGE);
    check(band_o, 32'h14);
    check(following_error_limit_o, 32'h46);
    issue(16'h0000, 16'h0f00, 32'h1, 32'h1, 32'h1, `SPCC_ERR_BAD_CMD);
    issue(16'h0000, 16'h0004, 32'h1, 32'h0, 32'h0, `SPCC_ERR_BAD_CMD);
    issue(16'h0000, 16'h0108, 32'h1, 32'h0, 32'h0, `SPCC_ERR_BAD_CMD);
    issue(16'h0001, 16'h0008, 32'h1, 32'h0, 32'h0, `SPCC_ERR_BAD_CMD);
    estop_i <= 1'b0;
    motion_i <= 1'b0;
  endtask : t_config

  task automatic t_offset;
    issue(16'h0000, 16'h0010, 32'hffff_fff9, 32'h0, 32'h0, `SPCC_ERR_NONE);
    end_i <= 32'h64;
    act_i <= 32'h71;
    repeat (3) @(posedge clk_i);
    check(target_o, 32'h5d);
    check({31'h0, in_position_o}, 32'h1);
    ce_i <= 1'b0;
    act_i <= 32'h72;
    repeat (3) @(posedge clk_i);
    check({31'h0, in_position_o}, 32'h1);
    ce_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({31'h0, in_position_o}, 32'h0);
    home_done_i <= 1'b1;
    @(posedge clk_i);
    home_done_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(offset_o, 32'h0);
  endtask : t_offset

  task automatic tally_and_finish;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_preset();
    t_refuse();
    t_config();
    t_offset();
    tally_and_finish();
  end

  // Watchdog well past the expected run length
  initial
  begin
    #75000;
    failures++;
    tally_and_finish();
  end
endmodule : tb

// file: rtl/spcc_device.sv
// Servo module end: preset position and online configuration command decoder
//
// Behaviour
// [R01] Preset is word5 bit3, word4 zero, param 6-7
// [R02] Preset loads command and absolute position
// [R03] Preset needs no estop, no motion, homed
// [R04] Failed preset reports an error code
// [R05] Out-of-range parameter flags error in word4
// [R06] Offset bit4 stored, added to absolute endpoints
// [R07] Offset cleared when homing completes
// [R08] Band bit8, range zero to travel limit
// [R09] In-position only inside band around endpoint
// [R10] Band and limit need no preconditions
// [R11] Limit bit9, range zero to travel limit
// [R12] Up to three upper bits, pairs in order
// [R13] Failed band or limit reports an error
// [R14] Host writes params then word5 weight (host here drives both in the same cycle)
// [R15] Act once per word5 zero-to-nonzero change
// [R16] Rejected request changes only error status
`include "spcc_params.svh"

module spcc_device #(
  parameter int POS_W = 32
) (
  input wire logic clk_i,                           // 40 MHz clock
  input wire logic reset_i,                         // Synchronous reset, active high
  input wire logic ce_i,                            // Clock enable, freezes state when low
  spcc_if.device link,                              // Backplane image words
  input wire logic estop_i,                         // Module is in emergency stop
  input wire logic motion_i,                        // Motion in progress
  input wire logic homed_i,                         // Axis has been homed
  input wire logic home_done_i,                     // Homing completed successfully, pulse
  input wire spcc_pkg::spcc_value_type following_error_i,  // Signed following error
  input wire spcc_pkg::spcc_value_type travel_limit_i,     // Positive axis travel limit
  input wire spcc_pkg::spcc_value_type actual_pos_i,       // Actual axis position
  input wire spcc_pkg::spcc_value_type move_end_i,         // Commanded absolute move end point
  output spcc_pkg::spcc_value_type cmd_pos_o,              // Commanded axis position
  output spcc_pkg::spcc_value_type abs_pos_o,              // Absolute axis position
  output spcc_pkg::spcc_value_type offset_o,               // Stored position offset
  output spcc_pkg::spcc_value_type band_o,                 // Online in-position band
  output spcc_pkg::spcc_value_type following_error_limit_o, // Online excess following-error limit
  output spcc_pkg::spcc_value_type target_o,               // Move end point with offset applied
  output logic in_position_o,                              // Axis inside the in-position band
  output logic cmd_done_o                                  // Command finished, one-cycle pulse
);
  import spcc_pkg::*;

  if (POS_W != 32)
  begin : g_width_check
    $error("POS_W must be 32: a value spans two 16-bit image words");
  end

  // Count of set bits of an upper-byte mask
  function automatic logic [3:0] count_bits(input logic [7:0] m);
    logic [3:0] n;
    n = 4'd0;
    for (int i = 0; i < 8; i++)
    begin
      n = n + {3'd0, m[i]};
    end
    return n;
  endfunction : count_bits

  // Parameter pair used by an upper-byte bit: lower set bits come first
  function automatic spcc_value_type pick_param(input logic [7:0] m, input logic [2:0] b,
                                                input spcc_params_type p);
    logic [3:0] slot;
    logic [7:0] below;
    below = m & ((8'h01 << b) - 8'h01);
    slot = count_bits(below);
    if (slot > 4'd2)
    begin
      slot = 4'd2;
    end
    return {p[2 * slot + 1], p[2 * slot]};
  endfunction : pick_param

  // Signed range check against the travel limit
  function automatic logic in_range(input spcc_value_type v, input spcc_value_type lim,
                                    input logic allow_neg);
    logic low_ok;
    low_ok = allow_neg ? (v >= -lim) : (v >= 32'sh0000_0000);
    return low_ok && (v <= lim);
  endfunction : in_range

  spcc_dev_state_type state;
  spcc_dev_state_type next_state;
  logic armed;
  spcc_word_type bits_q;
  spcc_word_type blk_q;
  spcc_params_type par_q;
  spcc_word_type err_q;
  spcc_word_type echo_q;

  // Decode of the latched request
  wire logic [7:0] lo_byte = blk_q[7:0];
  wire logic [7:0] hi_byte = blk_q[15:8];
  wire logic bits_clear = (bits_q == 16'h0000);
  wire logic is_preset = bits_clear && (lo_byte == `SPCC_PRESET_CMD) && (hi_byte == 8'h00); // R01
  wire logic is_offset = bits_clear && (lo_byte == `SPCC_OFFSET_CMD) && (hi_byte == 8'h00); // R06
  wire logic is_cfg = bits_clear && (lo_byte == 8'h00) && (hi_byte != 8'h00);
  wire logic want_band = is_cfg && hi_byte[`SPCC_BAND_BIT];                 // R08
  wire logic want_limit = is_cfg && hi_byte[`SPCC_FOLLOWING_ERROR_LIMIT_BIT]; // R11
  wire logic too_many = count_bits(hi_byte) > `SPCC_MAX_CFG_BITS;          // R12
  wire spcc_value_type first_val = {par_q[1], par_q[0]};                   // R01
  wire spcc_value_type band_val = pick_param(hi_byte, `SPCC_BAND_BIT, par_q);     // R12
  wire spcc_value_type limit_val = pick_param(hi_byte, `SPCC_FOLLOWING_ERROR_LIMIT_BIT, par_q); // R12
  wire logic first_ok = in_range(first_val, travel_limit_i, 1'b1);
  wire logic band_ok = !want_band || in_range(band_val, travel_limit_i, 1'b0);    // R08
  wire logic limit_ok = !want_limit || in_range(limit_val, travel_limit_i, 1'b0); // R11

  // Error code for the latched request, zero when it is accepted
  spcc_word_type next_err;
  always_comb
  begin
    next_err = `SPCC_ERR_NONE;
    if (is_preset)
    begin
      if (estop_i)                                                  // R03
        next_err = `SPCC_ERR_ESTOP;                                 // R04
      else if (motion_i)                                            // R03
        next_err = `SPCC_ERR_MOTION;                                // R04
      else if (!homed_i)                                            // R03
        next_err = `SPCC_ERR_NOT_HOMED;                             // R04
      else if (!first_ok)
        next_err = `SPCC_ERR_RANGE;                                 // R05
    end
    else if (is_offset)
    begin
      if (!first_ok)
        next_err = `SPCC_ERR_RANGE;                                 // R05
    end
    else if (is_cfg)
    begin
      if (too_many)
        next_err = `SPCC_ERR_BAD_CMD;                               // R12
      else if (!band_ok || !limit_ok)
        next_err = `SPCC_ERR_RANGE;                                 // R05 R13
    end
    else
    begin
      next_err = `SPCC_ERR_BAD_CMD;
    end
  end

  wire logic exec = (state == SPCC_DEV_EXEC);
  wire logic accept = exec && (next_err == `SPCC_ERR_NONE);        // R16
  wire logic start = armed && (link.blk_cmd != 16'h0000);          // R15

  always_comb
  begin
    next_state = state;
    unique case (state)
      SPCC_DEV_IDLE:
        if (start)
          next_state = SPCC_DEV_EXEC;
      SPCC_DEV_EXEC:
        next_state = SPCC_DEV_HOLD;
      SPCC_DEV_HOLD:
        if (link.blk_cmd == 16'h0000)                              // R15
          next_state = SPCC_DEV_IDLE;
      default:
        next_state = SPCC_DEV_IDLE;
    endcase
  end

  // Request capture and handshake
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state <= SPCC_DEV_IDLE;
      armed <= 1'b0;
      bits_q <= 16'h0000;
      blk_q <= 16'h0000;
      par_q <= '{default: 16'h0000};
      err_q <= `SPCC_ERR_NONE;
      echo_q <= 16'h0000;
      cmd_done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      state <= next_state;
      armed <= (link.blk_cmd == 16'h0000);                         // R15
      cmd_done_o <= exec;
      if (state == SPCC_DEV_IDLE && start)
      begin
        bits_q <= link.bit_cmd;
        blk_q <= link.blk_cmd;
        par_q <= link.param;
      end
      if (exec)
      begin
        err_q <= next_err;                                         // R05
        echo_q <= blk_q;
      end
      else if (next_state == SPCC_DEV_IDLE)
        echo_q <= 16'h0000;
    end
  end

  // Stored axis quantities
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cmd_pos_o <= `SPCC_POS_RESET;
      abs_pos_o <= `SPCC_POS_RESET;
      offset_o <= `SPCC_OFFSET_RESET;
      band_o <= `SPCC_BAND_RESET;
      following_error_limit_o <= `SPCC_FOLLOWING_ERROR_LIMIT_RESET;
    end
    else if (ce_i)
    begin
      if (accept && is_preset)
      begin
        cmd_pos_o <= first_val;                                    // R02
        abs_pos_o <= first_val + following_error_i;                // R02
      end
      if (accept && is_offset)
        offset_o <= first_val;                                     // R06
      else if (home_done_i)
        offset_o <= `SPCC_OFFSET_RESET;                            // R07
      if (accept && want_band)
        band_o <= band_val;                                        // R08 R10
      if (accept && want_limit)
        following_error_limit_o <= limit_val;                      // R11 R10
    end
  end

  // Offset end point and in-position zone
  wire spcc_value_type next_target = move_end_i + offset_o;        // R06
  wire spcc_value_type pos_diff = actual_pos_i - target_o;
  wire spcc_value_type pos_dist = pos_diff[31] ? -pos_diff : pos_diff;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      target_o <= `SPCC_POS_RESET;
      in_position_o <= 1'b0;
    end
    else if (ce_i)
    begin
      target_o <= next_target;
      in_position_o <= (pos_dist <= band_o);                       // R09
    end
  end

  assign link.err_status = err_q;                                  // R05
  assign link.blk_echo = echo_q;
endmodule : spcc_device

// file: rtl/spcc_host.sv
// Controller end: writes a block command and its parameters, collects the answer
`include "spcc_params.svh"

module spcc_host (
  input wire logic clk_i,                            // 40 MHz clock
  input wire logic reset_i,                          // Synchronous reset, active high
  input wire logic ce_i,                             // Clock enable, freezes state when low
  spcc_if.host link,                                 // Backplane image words
  input wire logic req_i,                            // Issue a command, pulse when idle
  input wire spcc_pkg::spcc_word_type bits_i,        // Word 4 value
  input wire spcc_pkg::spcc_word_type cmd_i,         // Word 5 weight, nonzero
  input wire spcc_pkg::spcc_value_type par0_i,       // Value for words 6-7
  input wire spcc_pkg::spcc_value_type par1_i,       // Value for words 8-9
  input wire spcc_pkg::spcc_value_type par2_i,       // Value for words 10-11
  output logic busy_o,                               // Command in flight
  output logic done_o,                               // Answer ready, one-cycle pulse
  output spcc_pkg::spcc_word_type err_o              // Error status of last command
);
  import spcc_pkg::*;

  spcc_host_state_type state;
  spcc_word_type bits_q;
  spcc_word_type blk_q;
  spcc_params_type par_q;

  wire logic take = (state == SPCC_HOST_IDLE) && req_i && (cmd_i != 16'h0000);
  wire logic answered = (state == SPCC_HOST_WAIT) && (link.blk_echo == blk_q);
  wire logic released = (state == SPCC_HOST_CLEAR) && (link.blk_echo == 16'h0000);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state <= SPCC_HOST_IDLE;
      bits_q <= 16'h0000;
      blk_q <= 16'h0000;
      par_q <= '{default: 16'h0000};
      err_o <= `SPCC_ERR_NONE;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      done_o <= released;
      unique case (state)
        SPCC_HOST_IDLE:
          if (take)
          begin
            // Parameters and weight go out together and are held until answered
            bits_q <= bits_i;
            blk_q <= cmd_i;                                        // R14
            par_q <= '{par0_i[15:0], par0_i[31:16], par1_i[15:0], par1_i[31:16],
                       par2_i[15:0], par2_i[31:16]};               // R14
            state <= SPCC_HOST_WAIT;
          end
        SPCC_HOST_WAIT:
          if (answered)
          begin
            err_o <= link.err_status;
            blk_q <= 16'h0000;                                     // R15
            state <= SPCC_HOST_CLEAR;
          end
        SPCC_HOST_CLEAR:
          if (released)
            state <= SPCC_HOST_IDLE;
        default:
          state <= SPCC_HOST_IDLE;
      endcase
    end
  end

  assign busy_o = (state != SPCC_HOST_IDLE);
  assign link.bit_cmd = bits_q;
  assign link.blk_cmd = blk_q;
  assign link.param = par_q;
endmodule : spcc_host

// file: rtl/spcc_if.sv
// Backplane image words between the controller and the servo module
interface spcc_if;
  import spcc_pkg::*;
  spcc_word_type bit_cmd;       // Output word 4
  spcc_word_type blk_cmd;       // Output word 5
  spcc_params_type param;       // Output words 6 to 11
  spcc_word_type err_status;    // Input word 4
  spcc_word_type blk_echo;      // Command being answered, zero when idle
  modport device (input bit_cmd, input blk_cmd, input param, output err_status, output blk_echo);
  modport host (output bit_cmd, output blk_cmd, output param, input err_status, input blk_echo);
endinterface : spcc_if

// file: rtl/spcc_params.svh
// Constants for the servo preset and online configuration command block
`ifndef SPCC_PARAMS_SVH
`define SPCC_PARAMS_SVH

// Output image word 5, lower byte commands
`define SPCC_PRESET_CMD 8'h08
`define SPCC_OFFSET_CMD 8'h10
// Output image word 5, upper byte configuration bits, offset within the byte
`define SPCC_BAND_BIT 3'd0
`define SPCC_FOLLOWING_ERROR_LIMIT_BIT 3'd1
`define SPCC_MAX_CFG_BITS 4'd3
// Number of parameter words following word 5 (words 6 to 11)
`define SPCC_PARAM_WORDS 6
// Error codes returned in input image word 4
`define SPCC_ERR_NONE 16'h0000
`define SPCC_ERR_ESTOP 16'h0001
`define SPCC_ERR_MOTION 16'h0002
`define SPCC_ERR_NOT_HOMED 16'h0003
`define SPCC_ERR_RANGE 16'h0004
`define SPCC_ERR_BAD_CMD 16'h0005
// Reset values of the stored quantities
`define SPCC_POS_RESET 32'h0000_0000
`define SPCC_OFFSET_RESET 32'h0000_0000
`define SPCC_BAND_RESET 32'h0000_0000
`define SPCC_FOLLOWING_ERROR_LIMIT_RESET 32'h0000_0000

`endif

// file: rtl/spcc_pkg.sv
// Types shared by both ends of the servo command link
package spcc_pkg;
  typedef logic [15:0] spcc_word_type;
  typedef logic signed [31:0] spcc_value_type;
  typedef spcc_word_type spcc_params_type [6];
  typedef enum logic [2:0]
  {
    SPCC_DEV_IDLE = 3'b001,
    SPCC_DEV_EXEC = 3'b010,
    SPCC_DEV_HOLD = 3'b100
  } spcc_dev_state_type;
  typedef enum logic [2:0]
  {
    SPCC_HOST_IDLE = 3'b001,
    SPCC_HOST_WAIT = 3'b010,
    SPCC_HOST_CLEAR = 3'b100
  } spcc_host_state_type;
endpackage : spcc_pkg
